// *** common/dcafs_defs.vh ***
`ifndef DCAFS_DEFS_VH
`define DCAFS_DEFS_VH
// Cycle slots within one conversion (serial clock count, 0 based)
`define DCAFS_SLOTS_PER_CONV   5'd16
`define DCAFS_TRACK_CYCLES     4'd3
`define DCAFS_HOLD_EDGE        4'd3
`define DCAFS_FIRST_DATA_SLOT  4'd4
`define DCAFS_CMD_BITS         4'd8
// Command byte field positions
`define DCAFS_CMD_CH_BIT       3
`define DCAFS_CMD_BAD_BIT      4
// Channel codes
`define DCAFS_CH_A             1'b0
`define DCAFS_CH_B             1'b1
// Result width
`define DCAFS_RES_BITS         12
`define DCAFS_RES_MSB          11
// Buffer depth
`define DCAFS_BUF_DEPTH        2
`endif

// *** design/dcafs_buf2.v ***
`timescale 1ns/10ps
// Two entry buffer between converter core and shifter
module dcafs_buf2 #(
	parameter WIDTH = 13
) (
	input  wire             clk_in,
	input  wire             rst_n_in,
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	output wire             out_valid_out,
	input  wire             out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem_reg [0:1]; // Storage flip-flops
	reg             wr_ptr_reg;    // Write index
	reg             rd_ptr_reg;    // Read index
	reg [1:0]       count_reg;     // Fill level
	wire            push;
	wire            pop;

	assign in_ready_out  = (count_reg != 2'd2);
	assign out_valid_out = (count_reg != 2'd0);
	assign out_data_out  = mem_reg[rd_ptr_reg];
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;

	////////////////////////////////////////////////////////////////////
	// Pointers and level
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'd0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			// Simultaneous push and pop keeps the level
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// Data store has no reset; valid gates it
	always @(posedge clk_in) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_in;
		end
	end
endmodule // dcafs_buf2

// *** design/dcafs_top.v ***
// What this block does
// - Track selected input first three clocks
// - Hold and convert clocks four to sixteen
// - Freeze sample at fourth falling edge
// - Work only while frame select low
// - Shift result out during each conversion
// - Command selects channel for next conversion
// - Sixteen clocks between conversion starts
// - Route at most one of two inputs, following tracking one core clock late
// - Result line high impedance when deselected
// - MSB first, starting fifth clock
// - Capture command on first eight rises
// - Channel in bit three, bit four flags illegal, default A
`timescale 1ns/10ps
`include "dcafs_defs.vh"
module dcafs_top (
	input  wire        CORE_CLK_IN,       // 10 MHz core clock
	input  wire        RST_N_IN,          // Async reset, active low
	input  wire        SER_CLK_IN,        // Host serial clock pin
	input  wire        FRAME_SEL_N_IN,    // Frame select, active low
	input  wire        CMD_DATA_IN,       // Serial command pin
	input  wire [11:0] CONV_RESULT_IN,    // Quantiser result word
	output reg         RESULT_DATA_OUT,   // Serial result line
	output reg         RESULT_OE_OUT,     // Result line drive enable
	output reg         TRACK_OUT,         // Sampler tracking
	output reg         HOLD_STROBE_OUT,   // Sample frozen, one pulse
	output reg         SEL_INPUT_A_OUT,   // Route analog_input_a
	output reg         SEL_INPUT_B_OUT,   // Route analog_input_b
	output reg         CMD_BAD_OUT        // Illegal code seen
);
	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	reg  [1:0]  sclk_sync_reg;   // Serial clock stages
	reg  [1:0]  fsel_sync_reg;   // Frame select stages
	reg  [1:0]  din_sync_reg;    // Command data stages
	reg         sclk_last_reg;   // Previous synced clock
	reg         fsel_last_reg;   // Previous synced frame select
	reg  [3:0]  cycle_reg;       // Clock slot in conversion
	reg         first_fall_reg;  // Waiting first fall of frame
	reg  [3:0]  rise_cnt_reg;    // Rising edges in conversion
	reg  [7:0]  cmd_shift_reg;   // Incoming command byte
	reg         next_ch_reg;     // Channel for next conversion
	reg         cur_ch_reg;      // Channel now tracked
	reg  [11:0] out_shift_reg;   // Outgoing result bits
	reg         bad_reg;         // Illegal bit for next conv
	wire        sclk_s;
	wire        fsel_n_s;
	wire        sclk_rise;
	wire        sclk_fall;
	wire        in_frame;
	// Buffer wiring
	reg         buf_push_reg;    // Push request to buffer
	reg  [12:0] buf_in_reg;      // Result plus bad flag
	wire        buf_in_ready;
	wire        buf_out_valid;
	wire [12:0] buf_out_data;
	wire        buf_pop;

	assign sclk_s    = sclk_sync_reg[1];
	assign fsel_n_s  = fsel_sync_reg[1];
	assign in_frame  = ~fsel_n_s;
	assign sclk_rise = in_frame & sclk_s & ~sclk_last_reg;
	// Frame opening with the clock resting low counts as the first fall
	assign sclk_fall = in_frame & ~sclk_s & (sclk_last_reg | fsel_last_reg);

	// Two flops per pin; only the second stage is read
	always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sclk_sync_reg <= 2'b00;
			fsel_sync_reg <= 2'b11;
			din_sync_reg  <= 2'b00;
			sclk_last_reg <= 1'b0;
			fsel_last_reg <= 1'b1;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[0], SER_CLK_IN};
			fsel_sync_reg <= {fsel_sync_reg[0], FRAME_SEL_N_IN};
			din_sync_reg  <= {din_sync_reg[0], CMD_DATA_IN};
			sclk_last_reg <= sclk_s;
			fsel_last_reg <= fsel_n_s;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Cycle counter; a cycle starts at a falling clock edge
	// Clock gated off outside the frame, so the first fall of
	// a frame begins slot 0 whatever level the clock rested at.
	always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			cycle_reg      <= 4'd0;
			first_fall_reg <= 1'b1;
			rise_cnt_reg   <= 4'd0;
		end else if (!in_frame) begin
			cycle_reg      <= 4'd0;
			first_fall_reg <= 1'b1;
			rise_cnt_reg   <= 4'd0;
		end else begin
			if (sclk_fall) begin
				first_fall_reg <= 1'b0;
				if (first_fall_reg) begin
					cycle_reg <= 4'd0;
				end else begin
					// Wraps at sixteen: back to back tracking
					cycle_reg <= cycle_reg + 4'd1;
				end
			end
			if (sclk_rise) begin
				if (rise_cnt_reg == 4'd15) begin
					rise_cnt_reg <= 4'd0;
				end else begin
					rise_cnt_reg <= rise_cnt_reg + 4'd1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Command capture on the first eight rising edges
	always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			cmd_shift_reg <= 8'h00;
			next_ch_reg   <= `DCAFS_CH_A;
			bad_reg       <= 1'b0;
		end else if (sclk_rise) begin
			if (rise_cnt_reg < `DCAFS_CMD_BITS) begin
				cmd_shift_reg <= {cmd_shift_reg[6:0],
					din_sync_reg[1]};
			end
			// Eighth bit in: latch channel for the next conversion
			if (rise_cnt_reg == (`DCAFS_CMD_BITS - 4'd1)) begin
				next_ch_reg <= cmd_shift_reg[`DCAFS_CMD_CH_BIT - 1];
				bad_reg     <= cmd_shift_reg[`DCAFS_CMD_BAD_BIT - 1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Track, hold and mux control
	always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			TRACK_OUT       <= 1'b0;
			HOLD_STROBE_OUT <= 1'b0;
			cur_ch_reg      <= `DCAFS_CH_A;
			SEL_INPUT_A_OUT <= 1'b0;
			SEL_INPUT_B_OUT <= 1'b0;
		end else begin
			HOLD_STROBE_OUT <= 1'b0;
			if (!in_frame) begin
				TRACK_OUT <= 1'b0;
			end else if (sclk_fall) begin
				if (first_fall_reg || cycle_reg == 4'd15) begin
					// New conversion: take channel chosen last time
					TRACK_OUT  <= 1'b1;
					cur_ch_reg <= next_ch_reg;
				end else if (cycle_reg == `DCAFS_HOLD_EDGE - 4'd1) begin
					// Fourth falling edge ends tracking
					TRACK_OUT       <= 1'b0;
					HOLD_STROBE_OUT <= 1'b1;
				end
			end
			// One switch only, registered from TRACK_OUT so it follows tracking one core clock late
			SEL_INPUT_A_OUT <= TRACK_OUT & (cur_ch_reg == `DCAFS_CH_A);
			SEL_INPUT_B_OUT <= TRACK_OUT & (cur_ch_reg == `DCAFS_CH_B);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Result into buffer at hold; buffer drains at next slot 4
	always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			buf_push_reg <= 1'b0;
			buf_in_reg   <= 13'h0000;
		end else begin
			if (buf_push_reg && buf_in_ready) begin
				buf_push_reg <= 1'b0;
			end
			if (HOLD_STROBE_OUT) begin
				buf_push_reg <= 1'b1;
				buf_in_reg   <= {bad_reg, CONV_RESULT_IN};
			end
		end
	end

	// Pop as the data slot opens; a stale word is dropped on frame end
	assign buf_pop = (sclk_fall && cycle_reg == `DCAFS_FIRST_DATA_SLOT - 4'd1)
		|| (!in_frame && buf_out_valid);

	dcafs_buf2 #(
		.WIDTH (13)
	) u_buf (
		.clk_in        (CORE_CLK_IN),
		.rst_n_in      (RST_N_IN),
		.in_valid_in   (buf_push_reg),
		.in_ready_out  (buf_in_ready),
		.in_data_in    (buf_in_reg),
		.out_valid_out (buf_out_valid),
		.out_ready_in  (buf_pop),
		.out_data_out  (buf_out_data)
	);

	////////////////////////////////////////////////////////////////////
	// Serial result shifter, changes on falling edges
	always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			out_shift_reg   <= 12'h000;
			RESULT_DATA_OUT <= 1'b0;
			RESULT_OE_OUT   <= 1'b0;
			CMD_BAD_OUT     <= 1'b0;
		end else begin
			RESULT_OE_OUT <= in_frame;
			if (!in_frame) begin
				RESULT_DATA_OUT <= 1'b0;
			end else if (sclk_fall) begin
				if (cycle_reg == `DCAFS_FIRST_DATA_SLOT - 4'd1) begin
					// Fifth clock: MSB, from buffer if ready
					if (buf_out_valid) begin
						RESULT_DATA_OUT <= buf_out_data[`DCAFS_RES_MSB];
						out_shift_reg   <= {buf_out_data[10:0], 1'b0};
						CMD_BAD_OUT     <= buf_out_data[12];
					end else begin
						RESULT_DATA_OUT <= 1'b0;
						out_shift_reg   <= 12'h000;
					end
				end else if (cycle_reg >= `DCAFS_FIRST_DATA_SLOT &&
					cycle_reg != 4'd15) begin
					RESULT_DATA_OUT <= out_shift_reg[`DCAFS_RES_MSB];
					out_shift_reg   <= {out_shift_reg[10:0], 1'b0};
				end else begin
					// Leading slots 0 to 3, before the MSB, send zero
					RESULT_DATA_OUT <= 1'b0;
				end
			end
		end
	end
	// Host side duty partial conversions are simply abandoned
endmodule // dcafs_top

// *** testbench/dcafs_host_model.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// Host serial port: clock stands high outside frames except during idle_toggle
module dcafs_host_model (
	output logic      sclk_out,   // Serial clock, 800 ns period
	output logic      fsel_n_out, // Frame select, active low
	output logic      cmd_out,    // Command line
	input  wire logic line_in     // Result line as seen on the wire
);
	logic [7:0]  cmdq [$];        // Commands, one per conversion
	logic [11:0] got [$];         // Result bits MSB down to LSB
	initial begin
		sclk_out = 1'b1;
		fsel_n_out = 1'b1;
		cmd_out = 1'b0;
	end
	// Clocks while deselected must be ignored
	task idle_toggle;
		repeat (4) begin
			sclk_out = 1'b0;
			#400 sclk_out = 1'b1;
			#400;
		end
	endtask
	// One frame of n whole conversions
	task frame(input int n);
		logic [7:0]  c;
		logic [11:0] w;
		fsel_n_out = 1'b0;
		#400;
		repeat (n) begin
			c = cmdq.pop_front();
			w = 12'h000;
			for (int s = 0; s < 16; s++) begin
				sclk_out = 1'b0;
				// Command MSB first, toggling filler afterwards
				cmd_out = (s < 8) ? c[7 - s] : ~cmd_out;
				#400 sclk_out = 1'b1;
				// Sample late in the high phase, data moves after falls
				#390 if (s > 3) w = {w[10:0], line_in};
				#10;
			end
			got.push_back(w);
		end
		fsel_n_out = 1'b1;
		#2000;
	endtask
endmodule // dcafs_host_model

// *** testbench/dcafs_top_assertions.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// Port level checker, core clock domain only
module dcafs_top_checker (
	input wire logic        CORE_CLK_IN,
	input wire logic        RST_N_IN,
	input wire logic        SER_CLK_IN,
	input wire logic        FRAME_SEL_N_IN,
	input wire logic        CMD_DATA_IN,
	input wire logic [11:0] CONV_RESULT_IN,
	input wire logic        RESULT_DATA_OUT,
	input wire logic        RESULT_OE_OUT,
	input wire logic        TRACK_OUT,
	input wire logic        HOLD_STROBE_OUT,
	input wire logic        SEL_INPUT_A_OUT,
	input wire logic        SEL_INPUT_B_OUT,
	input wire logic        CMD_BAD_OUT
);
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// Five cycles covers the two sync flops plus the output register
	sequence sel_idle_s; FRAME_SEL_N_IN[*5]; endsequence
	sequence sel_busy_s; (!FRAME_SEL_N_IN)[*5]; endsequence
	// No second freeze inside one 16 clock conversion
	sequence quiet_conv_s; !HOLD_STROBE_OUT throughout ##126 1; endsequence
	sequence track_span_s; TRACK_OUT[*8] ##[14:20] $fell(TRACK_OUT); endsequence
	oe_idle_a: assert property (sel_idle_s |-> !RESULT_OE_OUT)
		else $error("result line driven while deselected");
	oe_busy_a: assert property (sel_busy_s |-> RESULT_OE_OUT)
		else $error("result line not driven in frame");
	track_span_a: assert property ($rose(TRACK_OUT) |-> track_span_s)
		else $error("track span not three serial clocks");
	freeze_ends_a: assert property ($fell(TRACK_OUT) |-> ##[0:1] HOLD_STROBE_OUT)
		else $error("track ended without freeze");
	conv_spacing_a: assert property (HOLD_STROBE_OUT |=> quiet_conv_s)
		else $error("conversions closer than 16 clocks");
	hold_in_frame_a: assert property (HOLD_STROBE_OUT |-> RESULT_OE_OUT)
		else $error("freeze outside a frame");
	sel_onehot_a: assert property (!(SEL_INPUT_A_OUT && SEL_INPUT_B_OUT))
		else $error("both inputs routed");
	sel_tracking_a: assert property ((SEL_INPUT_A_OUT || SEL_INPUT_B_OUT)
		|-> (TRACK_OUT || $past(TRACK_OUT)))
		else $error("input routed outside tracking");
	// Back to back conversions restart tracking
	wrap_c: cover property (HOLD_STROBE_OUT ##[100:110] $rose(TRACK_OUT));
endmodule // dcafs_top_checker
bind dcafs_top dcafs_top_checker i_chk (.*);

// *** testbench/dual_channel_adc_frame_sequencer_bench.sv ***
`timescale 1ns/10ps
module dual_channel_adc_frame_sequencer_bench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [11:0] conv = 12'h000;   // Quantiser word
	wire         sclk, fsel_n, cmd, res_line;
	wire         dout, oe, trk, hold, sa, sb, bad;
	int          miscompares = 0;
	int          check_count = 0;
	int          ch;
	logic [7:0]  c;
	logic [1:0]  sel_seen = 2'b00;
	logic [1:0]  selq [$];
	logic [11:0] expq [$];
	int          expch [$];
	always #50 clk = ~clk;
	// Released line shows a changing pattern, never a stale bit
	assign res_line = oe ? dout : ~clk;
	dcafs_top i_dcafs_top (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
		.SER_CLK_IN(sclk), .FRAME_SEL_N_IN(fsel_n), .CMD_DATA_IN(cmd),
		.CONV_RESULT_IN(conv), .RESULT_DATA_OUT(dout), .RESULT_OE_OUT(oe),
		.TRACK_OUT(trk), .HOLD_STROBE_OUT(hold), .SEL_INPUT_A_OUT(sa),
		.SEL_INPUT_B_OUT(sb), .CMD_BAD_OUT(bad));
	dcafs_host_model i_dcafs_host_model (.sclk_out(sclk),
		.fsel_n_out(fsel_n), .cmd_out(cmd), .line_in(res_line));
	task check(input logic [11:0] seen, input logic [11:0] exp);
		if (seen !== exp) begin
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			miscompares++;
		end
		check_count++;
	endtask
	task close_out;
		if (miscompares == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Record routing and the word frozen at each sample instant
	always @(posedge clk) begin
		if (sa || sb) sel_seen <= {sa, sb};
		if (hold) begin
			check(12'(bad), 12'h000);
			selq.push_back(sel_seen);
			expq.push_back(conv);
			#1 conv = 12'($urandom);
		end
	end
	initial begin
		repeat (6000) @(posedge clk);
		miscompares++;
		close_out;
	end
	initial begin
		void'($urandom(18));
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		conv = 12'($urandom);
		repeat (4) @(posedge clk);
		// Host edges then land just after core edges, never on them
		#1;
		ch = 0;
		for (int f = 1; f <= 4; f++) begin
			i_dcafs_host_model.idle_toggle();
			for (int k = 0; k < f; k++) begin
				c = 8'($urandom) & 8'hEF;
				i_dcafs_host_model.cmdq.push_back(c);
				expch.push_back(ch);
				ch = c[3];
			end
			i_dcafs_host_model.frame(f);
			for (int k = 0; k < f; k++) begin
				check(i_dcafs_host_model.got.pop_front(),
					expq.pop_front());
				check(12'(selq.pop_front()),
					(expch.pop_front() != 0) ? 12'h001 : 12'h002);
			end
		end
		close_out;
	end
endmodule // dual_channel_adc_frame_sequencer_bench
